// ### hdl/irqrd_ctrl.sv
// Global interrupt disable, reset vector handshake and control register
// Contract
// - Control bit 5 blocks all interrupts when set
// - Reset asserted drives reset vector on bus
// - Reset vector held until second edge after release
// - Reset returns all registers to defaults
// - Fixed-priority core requests enabled out of reset
// - Read-only field shows captured vector bits 7-1
`timescale 1ns/1ps
`default_nettype none
`include "irqrd_regs.svh"

module irqrd_ctrl #(
  parameter int unsigned NUM_SRC = 16,
  parameter int unsigned VAB_W = `IRQRD_VAB_W,
  parameter logic [VAB_W-1:0] RESET_VEC = `IRQRD_RESET_VEC,
  parameter logic [6:0] VEC_BASE = `IRQRD_VEC_BASE
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [NUM_SRC-1:0] irq_src_in,
  input wire logic irq_taken_in,
  output logic irq_req_out,
  output logic [VAB_W-1:0] vector_addr_bus_out,
  output logic [7:0] core_fixed_irq_en_out
);

  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata;
    logic block;
    logic [6:0] vab_cap;
    logic [NUM_SRC-1:0] src_en;
    logic req;
    logic [VAB_W-1:0] vector_addr_bus;
    logic [7:0] fixed_en;
  } irqrd_state_t;

  irqrd_state_t st_q;
  irqrd_state_t st_d;
  irqrd_seq_if seq_if ();

  // nrst_in is the core reset issued by the system integration unit
  irqrd_rst_seq #(
    .HOLD_EDGES(2'(`IRQRD_HOLD_EDGES))
  ) u_seq (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .seq_if(seq_if)
  );

  logic [NUM_SRC-1:0] hit;
  logic [6:0] vec_num;
  logic found;
  logic [15:0] ctrl_rd;
  logic [15:0] srcen_rd;
  logic sel_ctrl;
  logic sel_srcen;
  logic [VAB_W-1:0] active_vec;

  assign hit = irq_src_in & st_q.src_en;
  assign sel_ctrl = (avs_address_in[7:2] == `IRQRD_CTRL_IDX);
  assign sel_srcen = (avs_address_in[7:2] == `IRQRD_SRCEN_IDX);
  // Reserved fields read back as the values software must write
  assign ctrl_rd = {st_q.req, `IRQRD_PRIO_RD, st_q.vab_cap, st_q.block,
                    `IRQRD_RSVD_HI, `IRQRD_RSVD_LO};
  assign srcen_rd = 16'(st_q.src_en);

  // Lowest-numbered enabled source wins the vector
  always_comb begin
    vec_num = VEC_BASE;
    found = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (hit[i]) begin
        vec_num = VEC_BASE + 7'(i);
        found = 1'b1;
      end
    end
  end

  assign active_vec = found ? VAB_W'({vec_num, 1'b0}) : '0;

  always_comb begin
    st_d = st_q;
    // One-wait-state slave: request seen on idle, answered next cycle
    if (st_q.wait_q && (avs_read_in || avs_write_in)) begin
      st_d.wait_q = 1'b0;
      st_d.rdata = sel_ctrl ? {16'h0000, ctrl_rd} :
                   sel_srcen ? {16'h0000, srcen_rd} : `IRQRD_RDATA_RST;
    end else if (!st_q.wait_q) begin
      st_d.wait_q = 1'b1;
      if (avs_write_in && sel_ctrl && avs_byteenable_in[0]) begin
        st_d.block = avs_writedata_in[5];
      end
      if (avs_write_in && sel_srcen) begin
        for (int i = 0; i < NUM_SRC; i++) begin
          if (avs_byteenable_in[i / 8]) begin
            st_d.src_en[i] = avs_writedata_in[i];
          end
        end
      end
    end
    if (irq_taken_in) begin
      st_d.vab_cap = st_q.vector_addr_bus[7:1];
    end
    st_d.req = !st_d.block && found;
    st_d.fixed_en = st_d.block ? `IRQRD_FIXED_NONE : `IRQRD_FIXED_ALL;
    // The core may sample the bus any time before the hold ends
    st_d.vector_addr_bus = seq_if.hold ? RESET_VEC : active_vec;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q.wait_q <= 1'b1;
      st_q.rdata <= `IRQRD_RDATA_RST;
      st_q.block <= `IRQRD_BLOCK_RST;
      st_q.vab_cap <= '0;
      st_q.src_en <= '0;
      st_q.req <= 1'b0;
      st_q.vector_addr_bus <= RESET_VEC;
      st_q.fixed_en <= `IRQRD_FIXED_ALL;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata_out = st_q.rdata;
  assign avs_waitrequest_out = st_q.wait_q;
  assign irq_req_out = st_q.req;
  assign vector_addr_bus_out = st_q.vector_addr_bus;
  assign core_fixed_irq_en_out = st_q.fixed_en;

  rst_vab_a: assert property (@(posedge clk_in)
    !nrst_in |=> vector_addr_bus_out == RESET_VEC)
    else $error("reset vector missing during reset");

  vab_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(nrst_in) |-> vector_addr_bus_out == RESET_VEC
      ##1 (vector_addr_bus_out == RESET_VEC && !seq_if.hold)
      ##1 vector_addr_bus_out == $past(active_vec))
    else $error("reset vector not held exactly to second edge");

  rst_defaults_a: assert property (@(posedge clk_in)
    !nrst_in |=> (!st_q.block && st_q.src_en == '0 && !irq_req_out
      && avs_waitrequest_out))
    else $error("register not at default after reset");

  fixed_en_a: assert property (@(posedge clk_in)
    !nrst_in ##1 (nrst_in && !st_q.block) |-> core_fixed_irq_en_out == `IRQRD_FIXED_ALL)
    else $error("fixed core requests not enabled out of reset");

  blk_holds_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    st_q.block |-> !irq_req_out && core_fixed_irq_en_out == `IRQRD_FIXED_NONE)
    else $error("request passed while globally blocked");

  blk_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!avs_waitrequest_out && avs_write_in && sel_ctrl && avs_byteenable_in[0])
      |=> st_q.block == $past(avs_writedata_in[5]))
    else $error("global block bit not written");

  rsvd_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!avs_waitrequest_out && avs_read_in && sel_ctrl)
      |-> avs_readdata_out[4:0] == {`IRQRD_RSVD_HI, `IRQRD_RSVD_LO})
    else $error("reserved control bits read wrong");

  vab_cap_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    irq_taken_in |=> st_q.vab_cap == $past(vector_addr_bus_out[7:1]))
    else $error("vector field not captured on take");

  req_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    irq_req_out |-> $past(|hit))
    else $error("request without enabled source");

  wait_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

  // Refused addresses answer zero and nothing ever lands in the upper half
  unmapped_rd_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!avs_waitrequest_out && avs_read_in && !sel_ctrl && !sel_srcen)
      |-> avs_readdata_out == `IRQRD_RDATA_RST)
    else $error("unmapped read returned data");

  rdata_hi_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read data not zero");

  srcen_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!avs_waitrequest_out && avs_write_in && sel_srcen && avs_byteenable_in[0])
      |=> st_q.src_en[7:0] == $past(avs_writedata_in[7:0]))
    else $error("source enable low byte not written");

  vab_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!seq_if.hold && !(|hit)) |=> vector_addr_bus_out == '0)
    else $error("bus not idle after reset vector ended");

  fixed_free_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !st_q.block |-> core_fixed_irq_en_out == `IRQRD_FIXED_ALL)
    else $error("fixed core requests off while not blocked");

  cap_stable_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !irq_taken_in |=> $stable(st_q.vab_cap))
    else $error("vector field changed without a take");

  take_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    irq_req_out ##1 irq_taken_in);
  release_c: cover property (@(posedge clk_in) $rose(nrst_in) ##2 !seq_if.hold);
  block_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    (|hit) && st_q.block);
  ctrl_read_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    !avs_waitrequest_out && avs_read_in && sel_ctrl);
  unblock_c: cover property (@(posedge clk_in) disable iff (!nrst_in) $fell(st_q.block));

endmodule : irqrd_ctrl

`default_nettype wire

// ### hdl/irqrd_regs.svh
// Register indices, field values, reset values and timing counts of the controller
`ifndef IRQRD_REGS_SVH
`define IRQRD_REGS_SVH

`define IRQRD_CTRL_IDX 6'h16
`define IRQRD_SRCEN_IDX 6'h17
`define IRQRD_RSVD_HI 3'h7
`define IRQRD_RSVD_LO 2'h0
`define IRQRD_PRIO_RD 2'h0
`define IRQRD_BLOCK_RST 1'h0
`define IRQRD_SRCEN_RST 16'h0000
`define IRQRD_FIXED_ALL 8'hFF
`define IRQRD_FIXED_NONE 8'h00
`define IRQRD_HOLD_EDGES 2
`define IRQRD_CNT_ONE 2'h1
`define IRQRD_CNT_RST 2'h0
`define IRQRD_RDATA_RST 32'h0000_0000
`define IRQRD_VAB_W 21
`define IRQRD_RESET_VEC 21'h00_0000
`define IRQRD_VEC_BASE 7'h10

`endif

// ### hdl/irqrd_pkg.sv
// Types used by the reset-release sequencer of the reset-vector controller
package irqrd_pkg;

  typedef struct packed {
    logic [1:0] cnt;
  } irqrd_seq_t;

endpackage : irqrd_pkg

// ### hdl/irqrd_seq_if.sv
// Link between the controller and its reset-release sequencer
`timescale 1ns/1ps
`default_nettype none

interface irqrd_seq_if;
  logic hold;
  modport seq (output hold);
  modport ctl (input hold);
endinterface : irqrd_seq_if

`default_nettype wire

// ### hdl/irqrd_rst_seq.sv
// Counts clock edges after reset release to end the reset vector
`timescale 1ns/1ps
`default_nettype none
`include "irqrd_regs.svh"

module irqrd_rst_seq #(
  parameter logic [1:0] HOLD_EDGES = 2'(`IRQRD_HOLD_EDGES)
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  irqrd_seq_if.seq seq_if
);

  irqrd_pkg::irqrd_seq_t st_q;
  irqrd_pkg::irqrd_seq_t st_d;
  logic [1:0] last_cnt;

  assign last_cnt = HOLD_EDGES - `IRQRD_CNT_ONE;
  // Reset vector stays selected until the counter reaches its last value
  assign seq_if.hold = (st_q.cnt != last_cnt);

  always_comb begin
    st_d = st_q;
    if (st_q.cnt != last_cnt) begin
      st_d.cnt = st_q.cnt + `IRQRD_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q.cnt <= `IRQRD_CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : irqrd_rst_seq

`default_nettype wire

// ### tb/irqrd_core_model.sv
// Core-side model that takes a raised interrupt after a short or long delay
`timescale 1ns/1ps
`default_nettype none

module irqrd_core_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic slow_in,
  input wire logic irq_req_in,
  output logic irq_taken_out
);
  logic req_q;
  logic [2:0] cnt_q;
  // A slow core lets the request stand several cycles before taking it
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      req_q <= 1'b0;
      cnt_q <= 3'h0;
      irq_taken_out <= 1'b0;
    end else begin
      req_q <= irq_req_in;
      irq_taken_out <= 1'b0;
      if (irq_req_in && !req_q) begin
        cnt_q <= slow_in ? 3'h4 : 3'h1;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
        irq_taken_out <= (cnt_q == 3'h1);
      end
    end
  end
endmodule : irqrd_core_model

`default_nettype wire

// ### tb/irqrd_ctrl_tb.sv
// Self-checking bench for the reset-vector and global-block controller
`timescale 1ns/1ps
`default_nettype none
`include "irqrd_regs.svh"

module irqrd_ctrl_tb;
  localparam logic [20:0] RV = 21'h1A5A5;
  logic clk_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
  logic taken, req, wreq;
  logic [7:0] ad = 8'h00, fx;
  logic [31:0] wd = 32'h0, rdo, rdat;
  logic [15:0] srcd = 16'h0, src, en, p;
  logic [20:0] vector_addr_bus, v;
  logic [6:0] cap = 7'h00;
  logic [3:0] be = 4'h3;
  int err_total = 0, checked = 0;

  irqrd_ctrl #(.RESET_VEC(RV)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdo), .avs_waitrequest_out(wreq),
    .irq_src_in(srcd), .irq_taken_in(taken), .irq_req_out(req),
    .vector_addr_bus_out(vector_addr_bus), .core_fixed_irq_en_out(fx));
  irqrd_core_model core (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow),
    .irq_req_in(req), .irq_taken_out(taken));

  initial forever #5 clk_in = ~clk_in;

  function automatic logic [20:0] vexp(input logic [15:0] q);
    for (int i = 0; i < 16; i++) if (q[i]) return 21'({7'(`IRQRD_VEC_BASE + i), 1'b0});
    return 21'h0;
  endfunction : vexp

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Request is held until waitrequest is sampled low; readdata taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= {16'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, 32'(wreq));
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer

  // Bus shows the reset vector until the second edge after release
  task automatic reset_run(input int n);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1 chk("vab_in_reset", 32'(RV), 32'(vector_addr_bus));
    chk("fixed_en_reset", 32'h0FF, 32'(fx));
    @(posedge clk_in) nrst_in <= 1'b1;
    @(posedge clk_in) #1 chk("vab_edge1", 32'(RV), 32'(vector_addr_bus));
    @(posedge clk_in) #1 chk("vab_edge2", 32'h0, 32'(vector_addr_bus));
    xfer(1'b0, 8'h58, 16'h0);
    chk("ctrl_reset", 32'h001C, rdat);
    xfer(1'b0, 8'h5C, 16'h0);
    chk("srcen_reset", 32'h0, rdat);
  endtask : reset_run

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    #100000;
    err_total++;
    conclude();
  end

  initial begin
    void'($urandom(35));
    reset_run(14);
    xfer(1'b0, 8'hF0, 16'h0);
    chk("unmapped", 32'h0, rdat);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      en = (k == 0) ? 16'h8000 : 16'($urandom);
      src = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0 : 16'($urandom);
      p = src & en;
      slow <= k[0];
      xfer(1'b1, 8'h5C, en);
      @(posedge clk_in) srcd <= src;
      repeat (10) @(posedge clk_in);
      v = vexp(p);
      if (|p) cap = v[7:1];
      #1 chk("irq_req", 32'(|p), 32'(req));
      chk("vab_vector", 32'(v), 32'(vector_addr_bus));
      xfer(1'b0, 8'h58, 16'h0);
      chk("ctrl_capture", {16'h0, |p, 2'h0, cap, 6'h1C}, rdat);
      @(posedge clk_in) srcd <= 16'h0;
      repeat (3) @(posedge clk_in);
    end
    $display("test vectors done");
    xfer(1'b1, 8'h5C, 16'hFFFF);
    @(posedge clk_in) srcd <= 16'h0001;
    repeat (10) @(posedge clk_in);
    cap = 7'(`IRQRD_VEC_BASE);
    be <= 4'h2;
    xfer(1'b1, 8'h58, 16'h003C);
    be <= 4'h3;
    #1 chk("req_lane_masked", 32'h1, 32'(req));
    xfer(1'b1, 8'h58, 16'h003C);
    #1 chk("req_blocked", 32'h0, 32'(req));
    chk("fixed_blocked", 32'h0, 32'(fx));
    xfer(1'b0, 8'h58, 16'h0);
    chk("ctrl_blocked", {16'h0, 1'b0, 2'h0, cap, 6'h3C}, rdat);
    xfer(1'b1, 8'h58, 16'h001C);
    repeat (2) @(posedge clk_in);
    #1 chk("req_unblocked", 32'h1, 32'(req));
    chk("fixed_unblocked", 32'h0FF, 32'(fx));
    $display("test block done");
    xfer(1'b1, 8'h58, 16'h003C);
    reset_run(4);
    $display("test midrun reset done");
    conclude();
  end
endmodule : irqrd_ctrl_tb

`default_nettype wire
